/* File: logic/smc_pkg.sv */
// shared constants and types for the serial management and configuration port
package smc_pkg;

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_PS   = 5000;                     // 200 MHz system clock
   localparam int unsigned RUN_CLR_TIME_US = 100;                      // run bit cleared within this after reset
   localparam int unsigned RUN_CLR_CYCLES  = (RUN_CLR_TIME_US * 1000000) / CLK_PERIOD_PS; // longest time, rounded down

   // ****************************************************************
   // register space
   // ****************************************************************
   localparam int unsigned REG_AW          = 8;                        // switch register address width
   localparam int unsigned REG_DW          = 8;                        // switch register data width
   localparam logic [7:0]  RUN_REG_ADDR    = 8'h01;                    // register holding the run bit
   localparam int unsigned RUN_BIT_POS     = 0;                        // run bit position
   localparam logic [7:0]  RUN_REG_RST     = 8'h00;                    // run bit value after reset

   // ****************************************************************
   // configuration port select pattern and spi commands
   // ****************************************************************
   localparam logic [1:0]  CPS_SPI         = 2'h2;                     // strap pattern 10 selects spi slave
   localparam logic [7:0]  SPI_CMD_READ    = 8'h03;                    // 00000011
   localparam logic [7:0]  SPI_CMD_WRITE   = 8'h02;                    // 00000010

   // ****************************************************************
   // management frame fields
   // ****************************************************************
   localparam int unsigned MD_PRE_LEN      = 32;                       // preamble ones
   localparam logic [1:0]  MD_START        = 2'h1;                     // start pattern 01
   localparam logic [1:0]  MD_OP_READ      = 2'h2;                     // opcode 10
   localparam logic [1:0]  MD_OP_WRITE     = 2'h1;                     // opcode 01
   localparam logic [1:0]  MD_EXT_SEL      = 2'h3;                     // phy addr bits 2:1 equal 11
   localparam int unsigned MD_HDR_BITS     = 14;                       // start+op+phy+reg bits
   localparam int unsigned MD_DATA_BITS    = 16;                       // data field
   localparam logic [7:0]  MD_PHY_REG_1D   = 8'h1D;                    // custom phy register 29
   localparam logic [7:0]  MD_PHY_REG_1F   = 8'h1F;                    // custom phy register 31
   localparam logic [4:0]  MD_PHY_STD_MAX  = 5'h05;                    // standard phy registers 0..5

   // spi slave states
   typedef enum logic [1:0] {
      SPI_CMD   = 2'b00,
      SPI_ADDR  = 2'b01,
      SPI_DATA  = 2'b10,
      SPI_IGN   = 2'b11
   } smc_spi_st_t;

   // management frame states
   typedef enum logic [2:0] {
      MD_IDLE   = 3'b000,
      MD_HDR    = 3'b001,
      MD_TA     = 3'b010,
      MD_RDATA  = 3'b011,
      MD_WDATA  = 3'b100
   } smc_md_st_t;

endpackage

/* File: logic/smc_regfile.sv */
// switch register array with two access ports and the run bit
`timescale 1ns/1ps
module smc_regfile
   import smc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              wr_a,          // port a write strobe (spi)
   input  wire logic [REG_AW-1:0] addr_a,
   input  wire logic [REG_DW-1:0] wdata_a,
   output logic      [REG_DW-1:0] rdata_a,       // combinational read
   input  wire logic              wr_b,          // port b write strobe (mdio)
   input  wire logic [REG_AW-1:0] addr_b,
   input  wire logic [REG_DW-1:0] wdata_b,
   output logic      [REG_DW-1:0] rdata_b,
   output logic                   run_bit        // switch run enable
);
   localparam int unsigned DEPTH = 1 << REG_AW;
   logic [REG_DW-1:0] mem_r   [DEPTH];           // register contents
   logic [REG_DW-1:0] mem_nxt [DEPTH];

   // ****************************************************************
   // next values; port a wins a same-cycle collision
   // ****************************************************************
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_nxt[i] = mem_r[i];
      end
      if (wr_b) begin
         mem_nxt[addr_b] = wdata_b;
      end
      if (wr_a) begin
         mem_nxt[addr_a] = wdata_a;
      end
   end

   // ****************************************************************
   // storage; only the run register needs a reset, contents otherwise
   // belong to the configuration loader outside this block
   // ****************************************************************
   always_ff @(posedge clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (srst && (i == int'(RUN_REG_ADDR))) begin
            mem_r[i] <= RUN_REG_RST;
         end else begin
            mem_r[i] <= mem_nxt[i];
         end
      end
   end

   assign rdata_a = mem_r[addr_a];
   assign rdata_b = mem_r[addr_b];
   assign run_bit = mem_r[RUN_REG_ADDR][RUN_BIT_POS];
endmodule

/* File: logic/smc_sync.sv */
// two flip-flop synchroniser with rising and falling edge detect
`timescale 1ns/1ps
module smc_sync
   import smc_pkg::*;
#(
   parameter int unsigned W = 1                  // number of bits synchronised
)(
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] din,                // asynchronous inputs
   output logic      [W-1:0] dout,               // synchronised level
   output logic      [W-1:0] rise,               // one-cycle pulse on rising edge
   output logic      [W-1:0] fall                // one-cycle pulse on falling edge
);
   logic [W-1:0] meta_r;                         // first stage, read only by second stage
   logic [W-1:0] sync_r;                         // second stage
   logic [W-1:0] prev_r;                         // delayed copy for edge detect
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_nxt;
   logic [W-1:0] prev_nxt;

   // ****************************************************************
   // next values
   // ****************************************************************
   always_comb begin
      meta_nxt = din;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
   end

   // ****************************************************************
   // registers; reset to high so an idle-high line makes no false edge
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_r <= '1;
         sync_r <= '1;
         prev_r <= '1;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign dout = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule

/* File: logic/smc_top.sv */
// serial configuration port: spi slave and mdio management slave
// Operation
// RL1 - board straps select to 10 for spi
// RL2 - run bit cleared within 100 us
// RL3 - master configures before setting run bit
// RL4 - spi input captured on rising clock
// RL5 - spi output launched on falling clock
// RL6 - spi commands 03 read, 02 write
// RL7 - address increments per byte while selected
// RL8 - burst address wraps to zero
// RL9 - management clock up to 10 MHz
// RL10 - frame: preamble, start, op, addresses, ta, data
// RL11 - read turnaround z then device zero
// RL12 - standard mode exposes phy registers only
// RL13 - op 10 with bits 11 is extended read
// RL14 - op 01 with bits 11 is extended write
// RL15 - address is phy 4,3,0 then reg
// RL16 - extended read upper byte zero
// RL17 - extended write ignores upper byte
// RL18 - extended reaches registers 00 to FF
// RL19 - extended frames share standard timing
// RL20 - spi command, address, data, msb first
`timescale 1ns/1ps
module smc_top
   import smc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [1:0]  config_port_select,  // strap pins
   input  wire logic        spi_select_low,      // spi slave select, active low
   input  wire logic        spi_serial_clock,    // spi clock from master
   input  wire logic        spi_serial_in,       // master out slave in
   output logic             spi_serial_out,      // master in slave out
   output logic             spi_serial_out_oe_n, // low while driving
   input  wire logic        mdc,                 // management clock
   input  wire logic        mdio_in,             // management data line level
   output logic             mdio_out,            // management data drive value
   output logic             mdio_oe_n,           // low while driving mdio
   output logic             run_enable,          // switching enabled
   output logic             phy_req,             // one-cycle phy register request
   output logic             phy_wr,              // phy request is a write
   output logic [4:0]       phy_port,            // phy address of request
   output logic [4:0]       phy_reg,             // phy register of request
   output logic [15:0]      phy_wdata,           // phy write data
   input  wire logic [15:0] phy_rdata            // phy read data, same clock
);
   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [4:0] s_lvl;                            // synchronised levels
   logic [4:0] s_rise;
   logic [4:0] s_fall;
   logic [1:0] cps_lvl;                          // synchronised strap
   smc_sync #(.W(5)) u_sync (
      .clk  (clk),
      .srst (srst),
      .din  ({mdio_in, mdc, spi_serial_in, spi_serial_clock, spi_select_low}),
      .dout (s_lvl),
      .rise (s_rise),
      .fall (s_fall)
   );
   smc_sync #(.W(2)) u_sync_cps (
      .clk  (clk),
      .srst (srst),
      .din  (config_port_select),
      .dout (cps_lvl),
      .rise (),
      .fall ()
   );
   wire sel_n    = s_lvl[0];
   wire sck_rise = s_rise[1];
   wire sck_fall = s_fall[1];
   wire sdi      = s_lvl[2];
   wire mdc_rise = s_rise[3];
   wire md_in    = s_lvl[4];
   wire spi_mode = (cps_lvl == CPS_SPI);         // strapped for spi slave [RL1]

   // ****************************************************************
   // register array
   // ****************************************************************
   logic              spi_wr;
   logic [7:0]        spi_addr_r;
   logic [7:0]        spi_wdata;
   logic [7:0]        spi_rdata;
   logic              md_wr;
   logic [7:0]        md_addr;
   logic [7:0]        md_wdata;
   logic [7:0]        md_rdata;
   logic              run_bit;
   smc_regfile u_regs (
      .clk     (clk),
      .srst    (srst),
      .wr_a    (spi_wr),
      .addr_a  (spi_addr_r),
      .wdata_a (spi_wdata),
      .rdata_a (spi_rdata),
      .wr_b    (md_wr),
      .addr_b  (md_addr),
      .wdata_b (md_wdata),
      .rdata_b (md_rdata),
      .run_bit (run_bit)
   );
   // synchronous reset clears the run bit on the first edge, well inside
   // the allowed window of RUN_CLR_CYCLES [RL2]
   assign run_enable = run_bit;              // software sets it last [RL3]

   // ****************************************************************
   // spi slave
   // ****************************************************************
   smc_spi_st_t spi_st_r, spi_st_nxt;           // byte phase
   logic [2:0]  spi_cnt_r, spi_cnt_nxt;         // bit in byte
   logic [7:0]  spi_sh_r, spi_sh_nxt;           // input shifter
   logic        spi_rd_r, spi_rd_nxt;           // read command seen
   logic [7:0]  spi_tx_r, spi_tx_nxt;           // output shifter
   logic        spi_so_r, spi_so_nxt;           // output pin value
   logic [7:0]  spi_addr_nxt;
   logic        spi_load_r, spi_load_nxt;       // load tx shifter at next fall
   wire  [7:0]  spi_byte = {spi_sh_r[6:0], sdi};

   // next state for the spi slave
   always_comb begin
      spi_st_nxt   = spi_st_r;
      spi_cnt_nxt  = spi_cnt_r;
      spi_sh_nxt   = spi_sh_r;
      spi_rd_nxt   = spi_rd_r;
      spi_tx_nxt   = spi_tx_r;
      spi_so_nxt   = spi_so_r;
      spi_addr_nxt = spi_addr_r;
      spi_load_nxt = spi_load_r;
      spi_wr       = 1'b0;
      spi_wdata    = spi_byte;
      if (sel_n || !spi_mode) begin
         // deselect ends any transfer [RL7]
         spi_st_nxt   = SPI_CMD;
         spi_cnt_nxt  = 3'h0;
         spi_load_nxt = 1'b0;
      end else begin
         if (sck_rise) begin
            // sample on rising edge, msb first [RL4] [RL20]
            spi_sh_nxt  = spi_byte;
            spi_cnt_nxt = spi_cnt_r + 3'h1;
            if (spi_cnt_r == 3'h7) begin
               case (spi_st_r)
                  SPI_CMD: begin
                     // only read and write are decoded [RL6]
                     if (spi_byte == SPI_CMD_READ) begin
                        spi_rd_nxt = 1'b1;
                        spi_st_nxt = SPI_ADDR;
                     end else if (spi_byte == SPI_CMD_WRITE) begin
                        spi_rd_nxt = 1'b0;
                        spi_st_nxt = SPI_ADDR;
                     end else begin
                        spi_st_nxt = SPI_IGN;
                     end
                  end
                  SPI_ADDR: begin
                     spi_addr_nxt = spi_byte;
                     spi_st_nxt   = SPI_DATA;
                     spi_load_nxt = spi_rd_r;
                  end
                  SPI_DATA: begin
                     spi_wr       = !spi_rd_r;
                     // 8-bit counter wraps past FF to 00 [RL7] [RL8]
                     spi_addr_nxt = spi_addr_r + 8'h01;
                     spi_load_nxt = spi_rd_r;
                  end
                  default: spi_st_nxt = SPI_IGN;
               endcase
            end
         end
         if (sck_fall) begin
            // launch on falling edge [RL5]
            if (spi_load_r) begin
               spi_so_nxt   = spi_rdata[7];
               spi_tx_nxt   = {spi_rdata[6:0], 1'b0};
               spi_load_nxt = 1'b0;
            end else begin
               spi_so_nxt = spi_tx_r[7];
               spi_tx_nxt = {spi_tx_r[6:0], 1'b0};
            end
         end
      end
   end

   // spi registers
   always_ff @(posedge clk) begin
      if (srst) begin
         spi_st_r   <= SPI_CMD;
         spi_cnt_r  <= 3'h0;
         spi_sh_r   <= 8'h00;
         spi_rd_r   <= 1'b0;
         spi_tx_r   <= 8'h00;
         spi_so_r   <= 1'b0;
         spi_addr_r <= 8'h00;
         spi_load_r <= 1'b0;
      end else begin
         spi_st_r   <= spi_st_nxt;
         spi_cnt_r  <= spi_cnt_nxt;
         spi_sh_r   <= spi_sh_nxt;
         spi_rd_r   <= spi_rd_nxt;
         spi_tx_r   <= spi_tx_nxt;
         spi_so_r   <= spi_so_nxt;
         spi_addr_r <= spi_addr_nxt;
         spi_load_r <= spi_load_nxt;
      end
   end
   assign spi_serial_out      = spi_so_r;
   // drive only during a selected read so the line is shared safely
   assign spi_serial_out_oe_n = !(spi_mode && !sel_n && spi_rd_r && spi_st_r == SPI_DATA);

   // ****************************************************************
   // mdio management slave, sampled on mdc rising edge [RL9]
   // ****************************************************************
   smc_md_st_t md_st_r, md_st_nxt;
   logic [5:0]  md_cnt_r, md_cnt_nxt;           // bit counter within phase
   logic [13:0] md_hdr_r, md_hdr_nxt;           // start, op, phy, reg
   logic [15:0] md_sh_r, md_sh_nxt;             // data shifter
   logic        md_ext_r, md_ext_nxt;           // extended access
   logic        md_out_r, md_out_nxt;
   logic        md_oen_r, md_oen_nxt;
   wire  [13:0] hdr_new  = {md_hdr_r[12:0], md_in};
   wire  [1:0]  f_op     = hdr_new[11:10];
   wire  [4:0]  f_phy    = hdr_new[9:5];
   wire  [4:0]  f_reg    = hdr_new[4:0];
   wire  [4:0]  phy_addr_field = md_hdr_r[9:5];
   wire  [4:0]  reg_addr_field = md_hdr_r[4:0];
   // phy 4,3,0 over reg 4:0 [RL15]; full 00..FF span [RL18]
   assign md_addr  = {phy_addr_field[4:3], phy_addr_field[0], reg_addr_field};
   assign md_wdata = {md_sh_r[6:0], md_in};     // d7..d0 with the last bit, upper byte dropped [RL17]
   wire   std_reg_ok = (reg_addr_field <= MD_PHY_STD_MAX) || ({3'h0, reg_addr_field} == MD_PHY_REG_1D)
                       || ({3'h0, reg_addr_field} == MD_PHY_REG_1F);

   // next state for the management slave
   always_comb begin
      md_st_nxt  = md_st_r;
      md_cnt_nxt = md_cnt_r;
      md_hdr_nxt = md_hdr_r;
      md_sh_nxt  = md_sh_r;
      md_ext_nxt = md_ext_r;
      md_out_nxt = md_out_r;
      md_oen_nxt = md_oen_r;
      md_wr      = 1'b0;
      phy_req    = 1'b0;
      phy_wr     = 1'b0;
      if (mdc_rise) begin
         case (md_st_r)
            MD_IDLE: begin
               // count preamble ones, then look for the zero of start [RL10]
               md_oen_nxt = 1'b1;
               if (md_in) begin
                  if (md_cnt_r != 6'(MD_PRE_LEN)) md_cnt_nxt = md_cnt_r + 6'h01;
               end else if (md_cnt_r == 6'(MD_PRE_LEN)) begin
                  md_st_nxt  = MD_HDR;
                  md_hdr_nxt = 14'h0000;
                  md_cnt_nxt = 6'h01;
               end else begin
                  md_cnt_nxt = 6'h00;
               end
            end
            MD_HDR: begin
               md_hdr_nxt = hdr_new;
               md_cnt_nxt = md_cnt_r + 6'h01;
               if (md_cnt_r == 6'(MD_HDR_BITS - 1)) begin
                  md_cnt_nxt = 6'h00;
                  // same frame shape for both modes [RL19]
                  md_ext_nxt = (f_phy[2:1] == MD_EXT_SEL);  // [RL13] [RL14]
                  if (hdr_new[13:12] != MD_START) begin
                     md_st_nxt = MD_IDLE;
                  end else if (f_op == MD_OP_READ) begin
                     md_st_nxt = MD_TA;
                     if (f_phy[2:1] != MD_EXT_SEL) begin
                        phy_req = 1'b1;                   // fetch phy word [RL12]
                     end
                  end else if (f_op == MD_OP_WRITE) begin
                     md_st_nxt = MD_TA;
                  end else begin
                     md_st_nxt = MD_IDLE;
                  end
               end
            end
            MD_TA: begin
               md_cnt_nxt = md_cnt_r + 6'h01;
               if (md_hdr_r[11:10] == MD_OP_READ) begin
                  if (md_cnt_r == 6'h00) begin
                     // first ta bit released by controller, second driven 0 [RL11]
                     md_out_nxt = 1'b0;
                     md_oen_nxt = 1'b0;
                     // extended read: upper byte zero [RL16]
                     md_sh_nxt  = md_ext_r ? {8'h00, md_rdata}
                                           : (std_reg_ok ? phy_rdata : 16'h0000);
                  end else begin
                     md_out_nxt = md_sh_r[15];
                     md_sh_nxt  = {md_sh_r[14:0], 1'b0};
                     md_cnt_nxt = 6'h01;
                     md_st_nxt  = MD_RDATA;
                  end
               end else if (md_cnt_r == 6'h01) begin
                  md_cnt_nxt = 6'h00;
                  md_st_nxt  = MD_WDATA;
               end
            end
            MD_RDATA: begin
               md_cnt_nxt = md_cnt_r + 6'h01;
               if (md_cnt_r == 6'(MD_DATA_BITS)) begin
                  md_oen_nxt = 1'b1;                      // idle released
                  md_cnt_nxt = 6'h00;
                  md_st_nxt  = MD_IDLE;
               end else begin
                  md_out_nxt = md_sh_r[15];
                  md_sh_nxt  = {md_sh_r[14:0], 1'b0};
               end
            end
            MD_WDATA: begin
               md_sh_nxt  = {md_sh_r[14:0], md_in};
               md_cnt_nxt = md_cnt_r + 6'h01;
               if (md_cnt_r == 6'(MD_DATA_BITS - 1)) begin
                  md_cnt_nxt = 6'h00;
                  md_st_nxt  = MD_IDLE;
                  if (md_ext_r) begin
                     md_wr = 1'b1;                        // store low byte [RL14] [RL17]
                  end else if (std_reg_ok) begin
                     phy_req = 1'b1;                      // phy registers only [RL12]
                     phy_wr  = 1'b1;
                  end
               end
            end
            default: md_st_nxt = MD_IDLE;
         endcase
      end
   end

   // management registers
   always_ff @(posedge clk) begin
      if (srst) begin
         md_st_r  <= MD_IDLE;
         md_cnt_r <= 6'h00;
         md_hdr_r <= 14'h0000;
         md_sh_r  <= 16'h0000;
         md_ext_r <= 1'b0;
         md_out_r <= 1'b0;
         md_oen_r <= 1'b1;
      end else begin
         md_st_r  <= md_st_nxt;
         md_cnt_r <= md_cnt_nxt;
         md_hdr_r <= md_hdr_nxt;
         md_sh_r  <= md_sh_nxt;
         md_ext_r <= md_ext_nxt;
         md_out_r <= md_out_nxt;
         md_oen_r <= md_oen_nxt;
      end
   end

   // write word for phy is the shifter plus incoming bit at frame end
   assign phy_wdata = {md_sh_r[14:0], md_in};
   assign phy_port  = (md_st_r == MD_HDR) ? f_phy : phy_addr_field;
   assign phy_reg   = (md_st_r == MD_HDR) ? f_reg : reg_addr_field;
   assign mdio_out  = md_out_r;
   assign mdio_oe_n = md_oen_r;
endmodule

/* File: verification/smc_master.sv */
// far-side master model: spi master and mdio management controller
`timescale 1ns/1ps
module smc_master
   import smc_pkg::*;
(
   input  wire logic clk, miso, md_out, md_oe_n,
   output logic      ss_n, sck, mosi, mdc, mdio  // clocks stand still between frames
);
   logic drv_r, dv_r;  // master drive enable and value
   // pull-up wins when nobody drives
   assign mdio = !md_oe_n ? md_out : (drv_r ? dv_r : 1'b1);
   initial begin ss_n = 1; sck = 0; mosi = 0; mdc = 0; drv_r = 0; dv_r = 1; end
   task automatic wt(input int n); repeat (n) @(negedge clk); endtask
   // msb first, 80 ns clock, sample on rise
   task automatic sbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i]; wt(8); sck = 1; rx[i] = miso; wt(8); sck = 0;
      end
   endtask
   // command, address, n data bytes under one select
   task automatic spi(input logic [7:0] c, a, input logic [15:0] wd, input int n, output logic [15:0] rd);
      logic [7:0] r;
      rd = '0; ss_n = 0; wt(8); sbyte(c, r); sbyte(a, r);
      for (int k = 0; k < n; k++) begin sbyte(wd[15-8*k -: 8], r); rd[15-8*k -: 8] = r; end
      wt(8); ss_n = 1; mosi = ~mosi; wt(16);
   endtask
   // 100 ns mdc keeps the 10 MHz ceiling; released for read ta
   task automatic mdf(input logic [1:0] op, input logic [9:0] ad, input logic [15:0] wd, output logic [16:0] rd);
      logic [63:0] f;
      f = {32'hFFFFFFFF, MD_START, op, ad, (op == MD_OP_READ) ? 2'h3 : 2'h2, wd};
      rd = '0; drv_r = 1;
      for (int i = 63; i >= 0; i--) begin
         if (i == 17 && op == MD_OP_READ) drv_r = 0;
         dv_r = f[i]; wt(10); mdc = 1; if (i < 17) rd[i] = mdio; wt(10); mdc = 0;
      end
      drv_r = 0; wt(20);
   endtask
endmodule

/* File: verification/smc_props.sv */
// assertion checker for the serial management port
`timescale 1ns/1ps
module smc_props
   import smc_pkg::*;
(
   input wire logic       clk, srst, spi_select_low, spi_serial_clock,
   input wire logic       spi_serial_out, spi_serial_out_oe_n, mdio_out,
   input wire logic       mdio_oe_n, run_enable, phy_req,
   input wire logic [4:0] phy_port
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence sel_idle; spi_select_low [*5]; endsequence    // select high long enough to pass sync
   sequence md_take; $fell(mdio_oe_n); endsequence        // device grabs the line
   a_run_reset: assert property ($fell(srst) |-> !run_enable) else $error("run set after reset");
   a_ta_zero: assert property (md_take |-> !mdio_out) else $error("ta not zero");
   a_md_hold: assert property (md_take |=> !mdio_oe_n [*8]) else $error("drive too short");
   a_md_release: assert property ($rose(mdio_oe_n) |=> mdio_oe_n [*8]) else $error("line retaken");
   a_ext_nophy: assert property (phy_req |-> phy_port[2:1] != MD_EXT_SEL) else $error("ext to phy");
   a_req_pulse: assert property (phy_req |=> !phy_req) else $error("request too long");
   a_sel_release: assert property (sel_idle |-> spi_serial_out_oe_n) else $error("out while idle");
   // a launch two cycles after a rise would mean the wrong clock edge
   a_spi_launch: assert property ($changed(spi_serial_out) && !spi_serial_out_oe_n
      |-> !$past(spi_serial_clock, 2)) else $error("launch not on fall");
endmodule
bind smc_top smc_props u_props (.*);

/* File: verification/tb_top.sv */
// self-checking bench for the serial management port
`timescale 1ns/1ps
module tb_top
   import smc_pkg::*;
;
   logic        clk = 0, srst = 1, ss_n, sck, mosi, mdc, mdio, miso, miso_oe_n, md_out, md_oe_n, run_en;
   logic        phy_req, phy_wr, pw;
   logic [4:0]  phy_port, phy_reg, pp, pr;   // pp/pr latch the last phy request
   logic [15:0] phy_wdata, pd, srd;
   logic [16:0] mrd;
   logic [1:0]  cps = CPS_SPI;                // strap, moved off 10 once
   int          fails = 0, tests_run = 0, cyc = 0;
   initial forever #2.5 clk = ~clk;
   smc_top dut (.clk(clk), .srst(srst), .config_port_select(cps), // strap for spi slave
      .spi_select_low(ss_n), .spi_serial_clock(sck), .spi_serial_in(mosi), .spi_serial_out(miso),
      .spi_serial_out_oe_n(miso_oe_n), .mdc(mdc), .mdio_in(mdio), .mdio_out(md_out), .mdio_oe_n(md_oe_n),
      .run_enable(run_en), .phy_req(phy_req), .phy_wr(phy_wr), .phy_port(phy_port), .phy_reg(phy_reg),
      .phy_wdata(phy_wdata), .phy_rdata(16'hC3A5));
   smc_master m (.clk(clk), .miso(miso ^ miso_oe_n), .md_out(md_out), .md_oe_n(md_oe_n), .ss_n(ss_n), .sck(sck),
      .mosi(mosi), .mdc(mdc), .mdio(mdio));
   // latch phy requests, cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (phy_req) begin pw <= phy_wr; pp <= phy_port; pr <= phy_reg; pd <= phy_wdata; end
      if (cyc == 40000) begin fails++; wrap_up(); end
   end
   task automatic chk(input logic [16:0] s, e);
      tests_run++;
      if (s !== e) begin fails++; $display("[FAIL] %0t ns: got %h want %h", $time, s, e); end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // burst across the top address, start, bad command, then strap off
   task automatic t_spi();
      m.spi(SPI_CMD_WRITE, 8'hFF, 16'h5AA5, 2, srd);
      m.spi(SPI_CMD_READ, 8'hFF, 16'h0000, 2, srd);
      chk(srd, 16'h5AA5);
      chk(run_en, 1'b0);
      m.spi(SPI_CMD_WRITE, RUN_REG_ADDR, 16'h0100, 1, srd);
      chk(run_en, 1'b1);
      m.spi(8'h0B, RUN_REG_ADDR, 16'h0000, 1, srd);
      chk(run_en, 1'b1);
      cps = 2'h0;
      m.spi(SPI_CMD_WRITE, RUN_REG_ADDR, 16'h0000, 1, srd);
      chk(run_en, 1'b1);
      cps = CPS_SPI;
      $display("t_spi done");
   endtask
   // extended access: address B4 and 01, junk upper byte
   task automatic t_ext();
      m.mdf(MD_OP_WRITE, 10'b10111_10100, 16'hFF3C, mrd);
      m.spi(SPI_CMD_READ, 8'hB4, 16'h0000, 1, srd);
      chk(srd[15:8], 8'h3C);
      m.spi(SPI_CMD_WRITE, 8'hB4, 16'hC700, 1, srd);
      m.mdf(MD_OP_READ, 10'b10111_10100, 16'h0000, mrd);
      chk(mrd, 17'h000C7);
      m.mdf(MD_OP_WRITE, 10'b00110_00001, 16'hAA01, mrd);
      chk(run_en, 1'b1);
      $display("t_ext done");
   endtask
   // standard phy read and write
   task automatic t_std();
      m.mdf(MD_OP_READ, 10'b00001_00001, 16'h0000, mrd);
      chk(mrd, 17'h0C3A5);
      chk({pw, pp, pr}, {1'b0, 5'h01, 5'h01});
      m.mdf(MD_OP_WRITE, 10'b00010_11111, 16'h1234, mrd);
      chk({pw, pp, pr}, {1'b1, 5'h02, 5'h1F});
      chk(pd, 16'h1234);
      m.mdf(MD_OP_READ, 10'b00001_00110, 16'h0000, mrd);
      chk(mrd, 17'h00000);
      $display("t_std done");
   endtask
   initial begin
      repeat (20) @(negedge clk);
      srst = 0;
      repeat (4) @(negedge clk);
      chk(run_en, 1'b0);
      t_spi();
      srst = 1;
      repeat (2) @(negedge clk);
      srst = 0;
      repeat (4) @(negedge clk);
      chk(run_en, 1'b0);
      t_ext();
      t_std();
      wrap_up();
   end
endmodule
